// File: rtl/coa_pkg.sv
package coa_pkg;

  // control window, byte offsets
  localparam logic [11:0] COA_OFF_INSTR = 12'h000;
  localparam logic [11:0] COA_OFF_ACC = 12'h004;
  localparam logic [11:0] COA_OFF_FLAGS = 12'h008;
  localparam logic [11:0] COA_OFF_INDEX = 12'h00C;
  localparam logic [11:0] COA_OFF_STACK = 12'h010;
  localparam logic [11:0] COA_OFF_PCH = 12'h014;
  localparam logic [11:0] COA_OFF_PCL = 12'h018;
  localparam logic [11:0] COA_OFF_STATUS = 12'h01C;

  // paddr[11:10] selects the window; paddr[9:2] is the byte address
  localparam logic [1:0] COA_WIN_CTRL = 2'h0;
  localparam logic [1:0] COA_WIN_RAM = 2'h1;
  localparam logic [1:0] COA_WIN_REGS = 2'h2;

  localparam logic [7:0] COA_RST_BYTE = 8'h00;
  localparam logic [15:0] COA_RST_INSTR = 16'h0000;
  localparam logic [15:0] COA_PC_STEP = 16'h0002;
  localparam int unsigned COA_FLAG_CARRY = 2;
  localparam int unsigned COA_FLAG_ZERO = 1;
  localparam int unsigned COA_MEM_DEPTH = 256;

  typedef enum logic [1:0] {
    COA_MODE_SRC_IMM = 2'h0,
    COA_MODE_SRC_DIR = 2'h1,
    COA_MODE_SRC_IDX = 2'h2,
    COA_MODE_DST_DIR = 2'h3
  } coa_mode_e;

  // source-immediate uses all four; other modes use bit 0 (0 acc, 1 index)
  typedef enum logic [1:0] {
    COA_TGT_ACC = 2'h0,
    COA_TGT_FLAGS = 2'h1,
    COA_TGT_STACK = 2'h2,
    COA_TGT_INDEX = 2'h3
  } coa_tgt_e;

  typedef enum logic [2:0] {
    COA_OP_MOV = 3'h0,
    COA_OP_ADD = 3'h1,
    COA_OP_ADC = 3'h2,
    COA_OP_SUB = 3'h3,
    COA_OP_SBB = 3'h4,
    COA_OP_AND = 3'h5,
    COA_OP_OR = 3'h6,
    COA_OP_XOR = 3'h7
  } coa_op_e;

  // opcode byte: [7] space, [6:5] target, [4:3] mode, [2:0] operation
  typedef struct packed {
    logic space;
    coa_tgt_e target;
    coa_mode_e mode;
    coa_op_e op;
  } coa_opcode_s;

  typedef struct packed {
    logic [7:0] value;
    logic carry;
    logic zero;
  } coa_alu_res_s;

endpackage

// File: rtl/coa_alu.sv
`timescale 1ns/10ps
`default_nettype none
module coa_alu
  import coa_pkg::*;
(
  // operation
  input var coa_op_e op,
  input wire logic carry_in,
  // operands: a is the destination side, b the source
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  // result
  output coa_alu_res_s res
);

  logic [8:0] wide;

  always_comb begin
    wide = 9'h000;
    unique case (op)
      COA_OP_MOV: wide = {1'b0, b};
      COA_OP_ADD: wide = {1'b0, a} + {1'b0, b};
      COA_OP_ADC: wide = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
      COA_OP_SUB: wide = {1'b0, a} - {1'b0, b};
      COA_OP_SBB: wide = {1'b0, a} - {1'b0, b} - {8'h00, carry_in};
      COA_OP_AND: wide = {1'b0, a & b};
      COA_OP_OR: wide = {1'b0, a | b};
      COA_OP_XOR: wide = {1'b0, a ^ b};
    endcase
    res.value = wide[7:0];
    res.carry = wide[8];
    res.zero = (wide[7:0] == 8'h00);
  end

endmodule
`default_nettype wire

// File: rtl/coa_mem.sv
`timescale 1ns/10ps
`default_nettype none
module coa_mem
  import coa_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = COA_MEM_DEPTH,
  localparam int unsigned IW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic wr_en,
  input wire logic [IW-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  // execution read port
  input wire logic [IW-1:0] rd_a_idx,
  output logic [WIDTH-1:0] rd_a_data,
  // bus read port
  input wire logic [IW-1:0] rd_b_idx,
  output logic [WIDTH-1:0] rd_b_data
);

  if (DEPTH < 2 || (1 << IW) != DEPTH) begin : g_bad_depth
    $error("coa_mem: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] cell_q [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cell_q[i] <= '0;
      end else if (wr_en && wr_idx == IW'(i)) begin
        cell_q[i] <= wr_data;
      end
    end
  end

  assign rd_a_data = cell_q[rd_a_idx];
  assign rd_b_data = cell_q[rd_b_idx];

endmodule
`default_nettype wire

// File: rtl/coa_core.sv
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module coa_core
  import coa_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } coa_state_e;

  coa_state_e state_q;
  logic [15:0] instr_q;
  logic [7:0] acc_q, flags_q, index_offset_q, stack_top_pointer_q;
  logic [7:0] prog_count_high_q, prog_count_low_q, last_addr_q;
  logic [31:0] prdata_q;
  logic pready_q;

  coa_opcode_s opc;
  logic [7:0] operand;
  logic exec, sel_index;
  logic [7:0] eff_addr, ram_rd, regs_rd, ram_bus_rd, regs_bus_rd;
  logic [7:0] mem_val, reg_src, imm_other, alu_a, alu_b;
  coa_alu_res_s alu_res;
  logic flag_upd, to_acc, to_index, to_flags, to_stack;
  logic mem_wr, ram_wr_en, regs_wr_en;
  logic [7:0] mem_wr_idx, mem_wr_data;
  logic [15:0] pc_now, pc_next;

  // bus decode
  logic acc_phase, bus_wr, ctrl_hit, mapped;
  logic [1:0] win;
  logic [11:0] ctrl_off;
  logic [31:0] rd_mux;

  assign acc_phase = psel && penable;
  assign bus_wr = acc_phase && pready_q && pwrite;
  assign win = paddr[11:10];
  assign ctrl_off = {2'b00, paddr[9:0]};
  assign ctrl_hit = (ctrl_off <= COA_OFF_STATUS) && (paddr[1:0] == 2'b00);
  assign mapped = (win == COA_WIN_CTRL) ? ctrl_hit :
                  ((win == COA_WIN_RAM) || (win == COA_WIN_REGS)) &&
                  (paddr[1:0] == 2'b00);

  // decode of the two-byte instruction
  assign opc = coa_opcode_s'(instr_q[7:0]);
  assign operand = instr_q[15:8];
  assign exec = (state_q == ST_EXEC);
  assign sel_index = opc.target[0];
  assign pc_now = {prog_count_high_q, prog_count_low_q};
  assign pc_next = pc_now + COA_PC_STEP;

  // indexed sum is 8 bits and wraps
  assign eff_addr = (opc.mode == COA_MODE_SRC_IDX) ?
                    operand + index_offset_q : operand;

  assign mem_val = opc.space ? regs_rd : ram_rd;
  assign reg_src = sel_index ? index_offset_q : acc_q;

  always_comb begin
    imm_other = acc_q;
    unique case (opc.target)
      COA_TGT_ACC: imm_other = acc_q;
      COA_TGT_FLAGS: imm_other = flags_q;
      COA_TGT_STACK: imm_other = stack_top_pointer_q;
      COA_TGT_INDEX: imm_other = index_offset_q;
    endcase
  end

  always_comb begin
    alu_a = reg_src;
    alu_b = mem_val;
    unique case (opc.mode)
      COA_MODE_SRC_IMM: begin
        alu_a = imm_other;
        alu_b = operand;
      end
      COA_MODE_SRC_DIR, COA_MODE_SRC_IDX: begin
        alu_a = reg_src;
        alu_b = mem_val;
      end
      COA_MODE_DST_DIR: begin
        alu_a = mem_val;
        alu_b = reg_src;
      end
    endcase
  end

  coa_alu u_alu (
    .op(opc.op),
    .carry_in(flags_q[COA_FLAG_CARRY]),
    .a(alu_a),
    .b(alu_b),
    .res(alu_res)
  );

  // destinations of the result
  assign to_acc = exec && (((opc.mode == COA_MODE_SRC_IMM) &&
                  (opc.target == COA_TGT_ACC)) ||
                  ((opc.mode inside {COA_MODE_SRC_DIR, COA_MODE_SRC_IDX}) &&
                  !sel_index));
  assign to_index = exec && (((opc.mode == COA_MODE_SRC_IMM) &&
                    (opc.target == COA_TGT_INDEX)) ||
                    ((opc.mode inside {COA_MODE_SRC_DIR, COA_MODE_SRC_IDX})
                    && sel_index));
  assign to_flags = exec && (opc.mode == COA_MODE_SRC_IMM) &&
                    (opc.target == COA_TGT_FLAGS);
  assign to_stack = exec && (opc.mode == COA_MODE_SRC_IMM) &&
                    (opc.target == COA_TGT_STACK);
  assign mem_wr = exec && (opc.mode == COA_MODE_DST_DIR);
  assign flag_upd = exec && (opc.op != COA_OP_MOV) && !to_flags;

  // memory write port: execution first, then the bus
  always_comb begin
    ram_wr_en = 1'b0;
    regs_wr_en = 1'b0;
    mem_wr_idx = paddr[9:2];
    mem_wr_data = pwdata[7:0];
    if (mem_wr) begin
      ram_wr_en = !opc.space;
      regs_wr_en = opc.space;
      mem_wr_idx = eff_addr;
      mem_wr_data = alu_res.value;
    end else if (bus_wr) begin
      ram_wr_en = (win == COA_WIN_RAM) && mapped;
      regs_wr_en = (win == COA_WIN_REGS) && mapped;
    end
  end

  coa_mem #(.WIDTH(8), .DEPTH(COA_MEM_DEPTH)) u_ram (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(ram_wr_en),
    .wr_idx(mem_wr_idx),
    .wr_data(mem_wr_data),
    .rd_a_idx(eff_addr),
    .rd_a_data(ram_rd),
    .rd_b_idx(paddr[9:2]),
    .rd_b_data(ram_bus_rd)
  );

  coa_mem #(.WIDTH(8), .DEPTH(COA_MEM_DEPTH)) u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(regs_wr_en),
    .wr_idx(mem_wr_idx),
    .wr_data(mem_wr_data),
    .rd_a_idx(eff_addr),
    .rd_a_data(regs_rd),
    .rd_b_idx(paddr[9:2]),
    .rd_b_data(regs_bus_rd)
  );

  // sequencing: a write of the instruction word runs it next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      instr_q <= COA_RST_INSTR;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (bus_wr && win == COA_WIN_CTRL && ctrl_off == COA_OFF_INSTR) begin
            instr_q <= pwdata[15:0];
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: state_q <= ST_IDLE;
      endcase
    end
  end

  function automatic logic ctrl_wr(input logic [11:0] off);
    ctrl_wr = bus_wr && (win == COA_WIN_CTRL) && (ctrl_off == off);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= COA_RST_BYTE;
    end else if (to_acc) begin
      acc_q <= alu_res.value;
    end else if (ctrl_wr(COA_OFF_ACC)) begin
      acc_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= COA_RST_BYTE;
    end else if (to_flags) begin
      flags_q <= alu_res.value;
    end else if (flag_upd) begin
      flags_q[COA_FLAG_CARRY] <= alu_res.carry;
      flags_q[COA_FLAG_ZERO] <= alu_res.zero;
    end else if (ctrl_wr(COA_OFF_FLAGS)) begin
      flags_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_offset_q <= COA_RST_BYTE;
    end else if (to_index) begin
      index_offset_q <= alu_res.value;
    end else if (ctrl_wr(COA_OFF_INDEX)) begin
      index_offset_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_top_pointer_q <= COA_RST_BYTE;
    end else if (to_stack) begin
      stack_top_pointer_q <= alu_res.value;
    end else if (ctrl_wr(COA_OFF_STACK)) begin
      stack_top_pointer_q <= pwdata[7:0];
    end
  end

  // none of these modes writes the program counter itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_count_high_q <= COA_RST_BYTE;
      prog_count_low_q <= COA_RST_BYTE;
    end else if (exec) begin
      prog_count_high_q <= pc_next[15:8];
      prog_count_low_q <= pc_next[7:0];
    end else begin
      if (ctrl_wr(COA_OFF_PCH)) begin
        prog_count_high_q <= pwdata[7:0];
      end
      if (ctrl_wr(COA_OFF_PCL)) begin
        prog_count_low_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_addr_q <= COA_RST_BYTE;
    end else if (exec && opc.mode != COA_MODE_SRC_IMM) begin
      last_addr_q <= eff_addr;
    end
  end

  // read mux; status: [0] busy, [15:8] last operand address
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (win == COA_WIN_RAM && mapped) begin
      rd_mux = {24'h00_0000, ram_bus_rd};
    end else if (win == COA_WIN_REGS && mapped) begin
      rd_mux = {24'h00_0000, regs_bus_rd};
    end else if (win == COA_WIN_CTRL && mapped) begin
      unique case (ctrl_off)
        COA_OFF_INSTR: rd_mux = {16'h0000, instr_q};
        COA_OFF_ACC: rd_mux = {24'h00_0000, acc_q};
        COA_OFF_FLAGS: rd_mux = {24'h00_0000, flags_q};
        COA_OFF_INDEX: rd_mux = {24'h00_0000, index_offset_q};
        COA_OFF_STACK: rd_mux = {24'h00_0000, stack_top_pointer_q};
        COA_OFF_PCH: rd_mux = {24'h00_0000, prog_count_high_q};
        COA_OFF_PCL: rd_mux = {24'h00_0000, prog_count_low_q};
        COA_OFF_STATUS: rd_mux = {16'h0000, last_addr_q, 7'h00, exec};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // one wait state: data captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc_phase && !pready_q;
      if (acc_phase && !pready_q && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = acc_phase && pready_q && !mapped;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic is_imm, is_arith;
  assign is_imm = (opc.mode == COA_MODE_SRC_IMM);
  assign is_arith = (opc.op != COA_OP_MOV);

  pc_step_two_a: assert property (
    exec |=> pc_now == $past(pc_now) + COA_PC_STEP)
    else $error("program counter did not advance by two");
  index_sum_a: assert property (
    exec && opc.mode == COA_MODE_SRC_IDX |->
    eff_addr == 8'(operand + index_offset_q))
    else $error("indexed address is not operand plus index");
  direct_addr_a: assert property (
    exec && opc.mode inside {COA_MODE_SRC_DIR, COA_MODE_DST_DIR} |->
    eff_addr == operand)
    else $error("direct address is not the operand");
  imm_to_stack_a: assert property (
    exec && is_imm && opc.target == COA_TGT_STACK && !is_arith |=>
    stack_top_pointer_q == $past(operand))
    else $error("immediate move missed the stack pointer");
  src_to_acc_a: assert property (
    exec && !is_imm && opc.mode != COA_MODE_DST_DIR && !sel_index |=>
    acc_q == $past(alu_res.value) && $stable(index_offset_q))
    else $error("source result not in accumulator");
  arith_second_a: assert property (
    exec && opc.mode == COA_MODE_SRC_DIR && opc.op == COA_OP_ADD |->
    alu_res.value == 8'(reg_src + mem_val))
    else $error("direct add ignored second source");
  dst_write_a: assert property (
    exec && opc.mode == COA_MODE_DST_DIR |->
    (ram_wr_en ^ regs_wr_en) && mem_wr_idx == operand &&
    (is_arith || mem_wr_data == reg_src))
    else $error("destination write wrong");
  dst_keep_regs_a: assert property (
    exec && opc.mode == COA_MODE_DST_DIR |=>
    $stable(acc_q) && $stable(index_offset_q))
    else $error("destination mode changed a register");
  one_cycle_exec_a: assert property (
    exec |=> !exec ##1 !exec)
    else $error("execution longer than one cycle");
  ready_wait_a: assert property (
    acc_phase && !pready_q |=> pready_q)
    else $error("bus answer not after one wait");

  imm_cov_c: cover property (exec && is_imm && opc.target == COA_TGT_FLAGS);
  idx_cov_c: cover property (exec && opc.mode == COA_MODE_SRC_IDX &&
    {1'b0, operand} + {1'b0, index_offset_q} > 9'h0FF);
  dst_cov_c: cover property (exec && opc.mode == COA_MODE_DST_DIR &&
    opc.space && is_arith);
  err_cov_c: cover property (pslverr);

endmodule
`default_nettype wire

// File: tb/tb_coa_core.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("unexpected %s exp %h got %h", nm, e, g); num_errors++; end end
module tb_coa_core;
  import coa_pkg::*;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h00000002;
  logic [7:0] acc_m, flg_m, idx_m, sp_m;
  logic [15:0] pc_m;
  logic [7:0] mem_m [2][256];

  coa_core uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [11:0] maddr(input logic s, input logic [7:0] a);
    return {(s ? COA_WIN_REGS : COA_WIN_RAM), a, 2'h0};
  endfunction

  // carry out (borrow for subtracts) in bit 8
  function automatic logic [8:0] alu(input logic [2:0] op,
                                     input logic [7:0] a, input logic [7:0] b,
                                     input logic c);
    case (op)
      3'h0: return {1'b0, b};
      3'h1: return {1'b0, a} + {1'b0, b};
      3'h2: return {1'b0, a} + {1'b0, b} + {8'h00, c};
      3'h3: return {1'b0, a} - {1'b0, b};
      3'h4: return {1'b0, a} - {1'b0, b} - {8'h00, c};
      3'h5: return {1'b0, a & b};
      3'h6: return {1'b0, a | b};
      default: return {1'b0, a ^ b};
    endcase
  endfunction

  task finish_test();
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      $display("unexpected pready exp 1 got %b", pready);
      num_errors++;
      finish_test();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] lo,
                    input logic [7:0] hi = 8'h00);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, {16'h0000, hi, lo}, d, e);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    logic er;
    apb(1'b0, a, 32'h00000000, d, er);
    `CHK(nm, e & m, d & m)
    `CHK("slverr", 1'b0, er)
  endtask

  task automatic zero_chk();
    acc_m = 8'h00;
    flg_m = 8'h00;
    idx_m = 8'h00;
    sp_m = 8'h00;
    pc_m = 16'h0000;
    foreach (mem_m[i, j]) mem_m[i][j] = 8'h00;
    rchk("acc", COA_OFF_ACC, 32'h0, 32'hFFFFFFFF);
    rchk("index", COA_OFF_INDEX, 32'h0, 32'hFFFFFFFF);
    rchk("stack", COA_OFF_STACK, 32'h0, 32'hFFFFFFFF);
    rchk("pch", COA_OFF_PCH, 32'h0, 32'hFFFFFFFF);
    rchk("pcl", COA_OFF_PCL, 32'h0, 32'hFFFFFFFF);
  endtask

  task automatic run(input logic [7:0] opc, input logic [7:0] opd,
                     input logic [7:0] xv);
    logic [1:0] md, tg;
    logic [7:0] ea, a, b, fm;
    logic [8:0] r;
    logic s;
    md = opc[4:3];
    tg = opc[6:5];
    s = opc[7];
    idx_m = xv;
    wr(COA_OFF_INDEX, idx_m);
    flg_m = 8'(rnd());
    wr(COA_OFF_FLAGS, flg_m);
    acc_m = 8'(rnd());
    wr(COA_OFF_ACC, acc_m);
    sp_m = 8'(rnd());
    wr(COA_OFF_STACK, sp_m);
    ea = (md == 2'h2) ? opd + idx_m : opd;
    mem_m[s][ea] = 8'(rnd());
    wr(maddr(s, ea), mem_m[s][ea]);
    case (md)
      2'h0: begin
        a = (tg == 2'h0) ? acc_m : (tg == 2'h1) ? flg_m :
            (tg == 2'h2) ? sp_m : idx_m;
        b = opd;
      end
      2'h3: begin
        a = mem_m[s][ea];
        b = tg[0] ? idx_m : acc_m;
      end
      default: begin
        a = tg[0] ? idx_m : acc_m;
        b = mem_m[s][ea];
      end
    endcase
    r = alu(opc[2:0], a, b, flg_m[2]);
    wr(COA_OFF_INSTR, opc, opd);
    fm = 8'hFF;
    if (md == 2'h0 && tg == 2'h1) flg_m = r[7:0];
    else if (opc[2:0] != 3'h0) begin
      flg_m[COA_FLAG_CARRY] = r[8];
      flg_m[COA_FLAG_ZERO] = (r[7:0] == 8'h00);
    end
    if (md == 2'h3) mem_m[s][ea] = r[7:0];
    else if (md == 2'h0 && tg == 2'h2) sp_m = r[7:0];
    else if (md != 2'h0 || tg != 2'h1) begin
      if (tg[0]) idx_m = r[7:0];
      else acc_m = r[7:0];
    end
    pc_m += COA_PC_STEP;
    rchk("instr", COA_OFF_INSTR, {16'h0, opd, opc}, 32'hFFFFFFFF);
    rchk("acc", COA_OFF_ACC, {24'h0, acc_m}, 32'hFFFFFFFF);
    rchk("flags", COA_OFF_FLAGS, {24'h0, flg_m}, {24'h0, fm});
    rchk("index", COA_OFF_INDEX, {24'h0, idx_m}, 32'hFFFFFFFF);
    rchk("stack", COA_OFF_STACK, {24'h0, sp_m}, 32'hFFFFFFFF);
    rchk("pch", COA_OFF_PCH, {24'h0, pc_m[15:8]}, 32'hFFFFFFFF);
    rchk("pcl", COA_OFF_PCL, {24'h0, pc_m[7:0]}, 32'hFFFFFFFF);
    rchk("status", COA_OFF_STATUS, {16'h0, ea, 8'h00},
         (md == 2'h0) ? 32'hFFFF00FF : 32'hFFFFFFFF);
    rchk("mem", maddr(s, ea), {24'h0, mem_m[s][ea]}, 32'hFFFFFFFF);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    $display("unexpected run length limit reached");
    num_errors++;
    finish_test();
  end

  initial begin
    logic [11:0] bad [4];
    logic [31:0] d;
    logic er;
    bad = '{12'h020, 12'h005, 12'hC00, 12'h00D};
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    zero_chk();
    foreach (bad[i]) begin
      apb(1'b1, bad[i], 32'h0000005A, d, er);
      `CHK("wr slverr", 1'b1, er)
      apb(1'b0, bad[i], 32'h00000000, d, er);
      `CHK("rd slverr", 1'b1, er)
      `CHK("rd data", 32'h00000000, d)
    end
    rchk("index", COA_OFF_INDEX, 32'h0, 32'hFFFFFFFF);
    // indexed sum wraps past 255
    run(8'h11, 8'hFF, 8'h05);
    // destination-direct add from index into register space
    run(8'hB9, 8'h08, 8'h21);
    // low byte carries into the high byte
    pc_m = 16'h12FE;
    wr(COA_OFF_PCH, 8'h12);
    wr(COA_OFF_PCL, 8'hFE);
    run(8'h00, 8'h3C, 8'h00);
    for (int i = 0; i < 128; i++) begin
      run({1'(rnd()), 7'(i)}, 8'(rnd()), 8'(rnd()));
    end
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    zero_chk();
    for (int i = 0; i < 40; i++) begin
      run(8'(rnd()), 8'(rnd()), 8'(rnd()));
    end
    finish_test();
  end
endmodule
`default_nettype wire
